// ### design/cfim_top.sv
// Functional notes
// - Masked identifier bits excluded from comparison
// - Record lowest matching filter in hit index
// - Single mode: one 32-bit filter, hit 0
// - Dual mode: two 16-bit filters, hits 0-1
// - Quad mode: four 8-bit filters, hits 0-3
// - Closed mode never copies nor sets full
// - Eleven sources onto four gated vectors
// - Transmit request when enabled buffer empty
// - Set full and receive request after frame end
// - Wakeup flag on activity in sleep or stop; request needs ack
// - Warning flags when counters reach 96
// - Error-passive flags when counters exceed 127
// - Bus-off flag when transmit counter exceeds 255
// - Both buffers full: discard, set overrun
// - Request holds while enabled flag set
// - Write one clears flag, zero keeps
// - Clear ignored while set condition persists
// - Error counters not host writable
// - Configuration writes only under soft reset
// - Transmit pin recessive in low-power modes
// - Clock gating per operating mode
// - Mode decode from stop, ack, soft reset
// Purpose: Acceptance filter, interrupt flags, config lock and mode decode
// Assumes: Counters come from the protocol engine and are read only here
// Notes: Clock gating is reported as enables, gating cells sit outside

`timescale 1ns/10ps
module cfim_top (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic cpu_stop,
   input wire logic sleep_ack,
   input wire logic soft_reset_lock,
   input wire logic global_irq_mask,
   input wire logic cfg_wr,
   input wire logic [3:0] cfg_sel,
   input wire logic [7:0] cfg_wdata,
   input wire logic [7:0] rx_flag_clr,
   input wire logic [2:0] tx_flag_clr,
   input wire logic [7:0] irq_en,
   input wire logic [2:0] tx_empty_irq_en,
   input wire logic [31:0] rx_id,
   input wire logic rx_eof_ok,
   input wire logic rx_own_msg,
   input wire logic bg_full,
   input wire logic [2:0] tx_buf_set_empty,
   input wire logic [2:0] tx_buf_sched,
   input wire logic bus_activity,
   input wire logic [7:0] rx_err_cnt,
   input wire logic [8:0] tx_err_cnt,
   input wire logic core_tx_bit,
   output logic [7:0] rx_flag_reg,
   output logic [2:0] tx_flag_reg,
   output logic [7:0] id_accept_control_reg,
   output logic [7:0] module_control1_reg,
   output logic [7:0] bus_timing0_reg,
   output logic [7:0] bus_timing1_reg,
   output logic [31:0] id_accept_pattern_regs,
   output logic [31:0] id_mask_regs,
   output logic fg_copy,
   output logic [1:0] op_mode,
   output logic proto_clk_en,
   output logic reg_clk_en,
   output logic can_tx_pin,
   output logic irq_wakeup,
   output logic irq_error,
   output logic irq_rx,
   output logic irq_tx
);
   cfim_filt_if fb ();
   cfim_pkg::cfim_fmode_e filt_mode;
   cfim_pkg::cfim_omode_e mode_dec;
   logic [1:0] filter_hit_index;
   logic [7:0] next_rx_flag;
   logic [2:0] next_tx_flag;

   cfim_acc_filter u_filter (
      .fb(fb)
   );

   assign filt_mode = cfim_pkg::cfim_fmode_e'(id_accept_control_reg[cfim_pkg::AC_MODE_LSB +: 2]);
   assign fb.id_word = rx_id;
   assign fb.pattern = id_accept_pattern_regs;
   assign fb.mask = id_mask_regs;
   assign fb.mode = filt_mode;

   // Mode decode
   wire in_sleep;
   wire in_sreset;
   wire low_power;
   assign mode_dec = cpu_stop ? cfim_pkg::OM_POWER_DOWN :
                     (sleep_ack && !soft_reset_lock) ? cfim_pkg::OM_SLEEP :
                     (!sleep_ack && soft_reset_lock) ? cfim_pkg::OM_SOFT_RESET :
                     cfim_pkg::OM_NORMAL;
   assign in_sleep = (mode_dec == cfim_pkg::OM_SLEEP);
   assign in_sreset = (mode_dec == cfim_pkg::OM_SOFT_RESET);
   assign low_power = (mode_dec != cfim_pkg::OM_NORMAL);

   // Acceptance and hit priority
   wire accepted;
   wire [1:0] hit_code;
   wire take_msg;
   wire rx_full_now;
   wire do_copy;
   wire do_overrun;
   assign accepted = |fb.hit_vec;
   assign hit_code = fb.hit_vec[0] ? 2'h0 :
                     fb.hit_vec[1] ? 2'h1 :
                     fb.hit_vec[2] ? 2'h2 : 2'h3;
   // Own frames are not delivered; sleep and soft reset also hold the copy back
   assign take_msg = rx_eof_ok && !rx_own_msg && accepted && !low_power &&
                     (filt_mode != cfim_pkg::FM_CLOSED);
   assign rx_full_now = rx_flag_reg[cfim_pkg::RF_RX_FULL];
   assign do_copy = take_msg && !rx_full_now;
   assign do_overrun = take_msg && rx_full_now && bg_full;

   // Error conditions, levels from the counters, plus the wake condition
   wire rx_warn_cond;
   wire tx_warn_cond;
   wire rx_pass_cond;
   wire tx_pass_cond;
   wire bus_off_cond;
   wire wake_cond;
   assign rx_warn_cond = (rx_err_cnt >= cfim_pkg::WARN_LIMIT);
   assign tx_warn_cond = (tx_err_cnt >= {1'b0, cfim_pkg::WARN_LIMIT});
   assign rx_pass_cond = ({1'b0, rx_err_cnt} > cfim_pkg::PASSIVE_LIMIT);
   assign tx_pass_cond = (tx_err_cnt > cfim_pkg::PASSIVE_LIMIT);
   assign bus_off_cond = (tx_err_cnt > cfim_pkg::BUS_OFF_LIMIT);
   assign wake_cond = bus_activity && (in_sleep || cpu_stop);

   wire [7:0] set_vec;
   wire [7:0] hold_vec;
   assign set_vec = {wake_cond, rx_warn_cond, tx_warn_cond, rx_pass_cond,
                     tx_pass_cond, bus_off_cond, do_overrun, do_copy};
   // Level conditions keep their flag; the event flags only need set over clear
   assign hold_vec = {wake_cond, rx_warn_cond, tx_warn_cond, rx_pass_cond,
                      tx_pass_cond, bus_off_cond, 2'h0};

   // Flag update: set wins, write one clears, zero keeps
   assign next_rx_flag = set_vec | hold_vec |
                         (rx_flag_reg & ~rx_flag_clr);
   // Buffers the host has handed over lose their empty flag
   assign next_tx_flag = tx_buf_set_empty | (tx_flag_reg & ~(tx_flag_clr | tx_buf_sched));

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rx_flag_reg <= cfim_pkg::RX_FLAG_RESET;
         tx_flag_reg <= cfim_pkg::TX_FLAG_RESET;
      end else begin
         rx_flag_reg <= next_rx_flag;
         tx_flag_reg <= next_tx_flag;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         filter_hit_index <= 2'h0;
         fg_copy <= 1'b0;
      end else begin
         fg_copy <= do_copy;
         if (do_copy) begin
            filter_hit_index <= hit_code;
         end
      end
   end

   // Configuration lock; error counters have no write path at all
   wire cfg_open;
   assign cfg_open = cfg_wr && soft_reset_lock;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         module_control1_reg <= cfim_pkg::MCR1_RESET;
         bus_timing0_reg <= cfim_pkg::BT_RESET;
         bus_timing1_reg <= cfim_pkg::BT_RESET;
         id_accept_control_reg <= cfim_pkg::AC_RESET;
         id_accept_pattern_regs <= {4{cfim_pkg::PAT_RESET}};
         id_mask_regs <= {4{cfim_pkg::MASK_RESET}};
      end else begin
         if (cfg_open) begin
            case (cfg_sel)
               4'h0: module_control1_reg <= cfg_wdata;
               4'h1: bus_timing0_reg <= cfg_wdata;
               4'h2: bus_timing1_reg <= cfg_wdata;
               4'h3: id_accept_control_reg[cfim_pkg::AC_MODE_LSB +: 2] <= cfg_wdata[5:4];
               4'h4: id_accept_pattern_regs[31:24] <= cfg_wdata;
               4'h5: id_accept_pattern_regs[23:16] <= cfg_wdata;
               4'h6: id_accept_pattern_regs[15:8] <= cfg_wdata;
               4'h7: id_accept_pattern_regs[7:0] <= cfg_wdata;
               4'h8: id_mask_regs[31:24] <= cfg_wdata;
               4'h9: id_mask_regs[23:16] <= cfg_wdata;
               4'ha: id_mask_regs[15:8] <= cfg_wdata;
               4'hb: id_mask_regs[7:0] <= cfg_wdata;
               default: ;
            endcase
         end
         id_accept_control_reg[cfim_pkg::AC_HIT_LSB +: 2] <= filter_hit_index;
      end
   end

   // Interrupt vectors, each source gated locally then by the global mask
   wire [7:0] rx_enabled;
   wire [2:0] tx_enabled;
   wire next_irq_wakeup;
   wire next_irq_error;
   wire next_irq_rx;
   wire next_irq_tx;
   assign rx_enabled = rx_flag_reg & irq_en;
   assign tx_enabled = tx_flag_reg & tx_empty_irq_en;
   assign next_irq_wakeup = rx_enabled[cfim_pkg::RF_WAKEUP] && sleep_ack &&
                            !global_irq_mask;
   assign next_irq_error = (|rx_enabled[cfim_pkg::RF_RX_WARN:cfim_pkg::RF_OVERRUN]) &&
                           !global_irq_mask;
   assign next_irq_rx = rx_enabled[cfim_pkg::RF_RX_FULL] && !global_irq_mask;
   assign next_irq_tx = (|tx_enabled) && !global_irq_mask;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_wakeup <= 1'b0;
         irq_error <= 1'b0;
         irq_rx <= 1'b0;
         irq_tx <= 1'b0;
      end else begin
         irq_wakeup <= next_irq_wakeup;
         irq_error <= next_irq_error;
         irq_rx <= next_irq_rx;
         irq_tx <= next_irq_tx;
      end
   end

   // Mode outputs, clock enables and transmit pin
   always_ff @(posedge core_clk) begin
      if (srst) begin
         op_mode <= 2'h0;
         proto_clk_en <= 1'b0;
         reg_clk_en <= 1'b1;
         can_tx_pin <= 1'b1;
      end else begin
         op_mode <= mode_dec;
         proto_clk_en <= !low_power;
         reg_clk_en <= !cpu_stop;
         can_tx_pin <= low_power ? 1'b1 : core_tx_bit;
      end
   end
endmodule // cfim_top

// ### design/cfim_pkg.sv
// Purpose: Shared constants for the CAN filter, flag and mode block
// Assumes: Byte-wide configuration registers written over plain ports
// Notes: Flag bit positions follow the receive and transmit flag layouts

package cfim_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam logic [7:0] WARN_LIMIT = 8'h60;
   localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
   localparam logic [8:0] BUS_OFF_LIMIT = 9'h0ff;
   // Receive flag register bit positions
   localparam int unsigned RF_WAKEUP = 7;
   localparam int unsigned RF_RX_WARN = 6;
   localparam int unsigned RF_TX_WARN = 5;
   localparam int unsigned RF_RX_PASS = 4;
   localparam int unsigned RF_TX_PASS = 3;
   localparam int unsigned RF_BUS_OFF = 2;
   localparam int unsigned RF_OVERRUN = 1;
   localparam int unsigned RF_RX_FULL = 0;
   localparam logic [7:0] RX_FLAG_RESET = 8'h00;
   localparam logic [2:0] TX_FLAG_RESET = 3'h7;
   // Acceptance control register fields
   localparam int unsigned AC_MODE_LSB = 4;
   localparam int unsigned AC_HIT_LSB = 0;
   localparam logic [7:0] AC_RESET = 8'h00;
   localparam logic [7:0] MCR1_RESET = 8'h00;
   localparam logic [7:0] BT_RESET = 8'h00;
   localparam logic [7:0] PAT_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   typedef enum logic [1:0] {FM_SINGLE, FM_DUAL, FM_QUAD, FM_CLOSED} cfim_fmode_e;
   typedef enum logic [1:0] {OM_NORMAL, OM_SLEEP, OM_SOFT_RESET, OM_POWER_DOWN} cfim_omode_e;
endpackage

// ### design/cfim_filt_if.sv
// Purpose: Carries filter bank settings and match results between modules
// Assumes: Four byte lanes of pattern and mask
// Notes: Identifier is presented as four aligned bytes

`timescale 1ns/10ps
interface cfim_filt_if;
   logic [31:0] id_word;
   logic [31:0] pattern;
   logic [31:0] mask;
   cfim_pkg::cfim_fmode_e mode;
   logic [3:0] hit_vec;
   modport ctrl (output id_word, output pattern, output mask, output mode, input hit_vec);
   modport filt (input id_word, input pattern, input mask, input mode, output hit_vec);
endinterface

// ### design/cfim_acc_filter.sv
// Purpose: Maskable identifier acceptance filter bank
// Assumes: Mask bit 1 marks a don't-care bit
// Notes: Purely combinational, results registered by the caller

`timescale 1ns/10ps
module cfim_acc_filter (
   cfim_filt_if.filt fb
);
   wire [31:0] bit_eq;
   wire [31:0] bit_ok;
   wire full_hit;
   wire [1:0] half_hit;
   wire [3:0] quad_hit;
   assign bit_eq = ~(fb.id_word ^ fb.pattern);
   assign bit_ok = bit_eq | fb.mask;
   assign full_hit = &bit_ok;
   assign half_hit[0] = &bit_ok[31:16];
   assign half_hit[1] = &bit_ok[15:0];
   assign quad_hit[0] = &bit_ok[31:24];
   assign quad_hit[1] = &bit_ok[23:16];
   assign quad_hit[2] = &bit_ok[15:8];
   assign quad_hit[3] = &bit_ok[7:0];
   assign fb.hit_vec = (fb.mode == cfim_pkg::FM_SINGLE) ? {3'h0, full_hit} :
                       (fb.mode == cfim_pkg::FM_DUAL) ? {2'h0, half_hit} :
                       (fb.mode == cfim_pkg::FM_QUAD) ? quad_hit : 4'h0;
endmodule // cfim_acc_filter

// ### sim/cfim_top_checker.sv
// Purpose: Port-level property checks for the filter, flag and mode block
// Assumes: Flags and requests are registered one edge after their cause
// Notes: The ack-plus-soft-reset mode combination is left unchecked
`timescale 1ns/10ps
module cfim_top_checker (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic cpu_stop,
   input wire logic sleep_ack,
   input wire logic soft_reset_lock,
   input wire logic global_irq_mask,
   input wire logic [7:0] irq_en,
   input wire logic [2:0] tx_empty_irq_en,
   input wire logic rx_eof_ok,
   input wire logic [7:0] rx_err_cnt,
   input wire logic [8:0] tx_err_cnt,
   input wire logic [7:0] rx_flag_reg,
   input wire logic [2:0] tx_flag_reg,
   input wire logic fg_copy,
   input wire logic [1:0] op_mode,
   input wire logic reg_clk_en,
   input wire logic can_tx_pin,
   input wire logic irq_wakeup,
   input wire logic irq_error,
   input wire logic irq_rx,
   input wire logic irq_tx
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence s_copy; fg_copy && irq_en[0] && !global_irq_mask; endsequence
   property p_copy_cause; fg_copy |-> $past(rx_eof_ok) && rx_flag_reg[0]; endproperty
   a_copy_cause: assert property (p_copy_cause) else $error("copy without frame end");
   property p_rx_irq; s_copy |=> irq_rx; endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("receive request missing");
   property p_warn; rx_err_cnt >= 8'h60 |=> rx_flag_reg[6]; endproperty
   a_warn: assert property (p_warn) else $error("receive warning flag missing");
   property p_bus_off; tx_err_cnt > 9'h0ff |=> rx_flag_reg[2] && rx_flag_reg[3]; endproperty
   a_bus_off: assert property (p_bus_off) else $error("bus off flag missing");
   // Skip the edge after a reset, where past values predate it
   property p_err_vec;
      !$past(srst) |-> irq_error == $past((|(rx_flag_reg[6:1] & irq_en[6:1])) && !global_irq_mask);
   endproperty
   a_err_vec: assert property (p_err_vec) else $error("error request wrong");
   property p_tx_irq; (|(tx_flag_reg & tx_empty_irq_en)) && !global_irq_mask |=> irq_tx; endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("transmit request missing");
   property p_wake; irq_wakeup |-> $past(sleep_ack) && $past(irq_en[7]); endproperty
   a_wake: assert property (p_wake) else $error("wakeup request without ack");
   // Ack and soft reset together decode as normal, so only the listed modes count
   property p_pin; cpu_stop || (sleep_ack != soft_reset_lock) |=> can_tx_pin; endproperty
   a_pin: assert property (p_pin) else $error("transmit pin not recessive");
   property p_stop; cpu_stop |=> op_mode == 2'h3 && !reg_clk_en; endproperty
   a_stop: assert property (p_stop) else $error("power down not entered");
endmodule // cfim_top_checker
bind cfim_top cfim_top_checker i_cfim_top_checker (.core_clk, .srst, .cpu_stop, .sleep_ack,
   .soft_reset_lock, .global_irq_mask, .irq_en, .tx_empty_irq_en, .rx_eof_ok, .rx_err_cnt,
   .tx_err_cnt, .rx_flag_reg, .tx_flag_reg, .fg_copy, .op_mode, .reg_clk_en, .can_tx_pin,
   .irq_wakeup, .irq_error, .irq_rx, .irq_tx);

// ### sim/cfim_can_node.sv
// Purpose: Remote bus node that delivers received frames
// Assumes: Frame length in cycles is set per frame, one at least
// Notes: Id lines toggle outside frames so a stale id never matches
`timescale 1ns/10ps
module cfim_can_node (
   input wire logic core_clk,
   input wire logic send,
   input wire logic [31:0] send_id,
   input wire logic [3:0] frame_len,
   output logic [31:0] rx_id,
   output logic rx_eof_ok,
   output logic bus_activity
);
   logic [3:0] cnt = 4'h0;
   logic [31:0] id_hold = 32'h0;
   initial begin
      rx_id = 32'h0;
      rx_eof_ok = 1'b0;
      bus_activity = 1'b0;
   end
   always @(posedge core_clk) begin
      rx_eof_ok <= 1'b0;
      rx_id <= ~rx_id;
      if (send) begin
         cnt <= frame_len;
         id_hold <= send_id;
         bus_activity <= 1'b1;
      end else if (cnt == 4'h1) begin
         rx_eof_ok <= 1'b1;
         rx_id <= id_hold;
         bus_activity <= 1'b0;
         cnt <= 4'h0;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule // cfim_can_node

// ### sim/cfim_top_test.sv
// Purpose: Self-checking bench for the filter, flag and mode block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Dual and quad ids match under either lane reading
`timescale 1ns/10ps
module cfim_top_test;
   logic core_clk = 1'b0, srst = 1'b1, cpu_stop = 1'b0, sleep_ack = 1'b0, soft_reset_lock = 1'b0;
   logic global_irq_mask = 1'b0, cfg_wr = 1'b0, bg_full = 1'b0, send = 1'b0, own_msg = 1'b0;
   logic rx_eof_ok, bus_activity, fg_copy, reg_clk_en, can_tx_pin, proto_clk_en;
   logic irq_wakeup, irq_error, irq_rx, irq_tx;
   logic [1:0] op_mode;
   logic [2:0] tx_flag_clr = 3'h0, tx_empty_irq_en = 3'h0, tx_buf_set_empty = 3'h0;
   logic [2:0] tx_buf_sched = 3'h0, tx_flag_reg;
   logic [3:0] cfg_sel = 4'h0, frame_len = 4'h1;
   logic [7:0] cfg_wdata = 8'h0, rx_flag_clr = 8'h0, irq_en = 8'hff, rx_err_cnt = 8'h0;
   logic [7:0] rx_flag_reg, id_accept_control_reg, module_control1_reg, bus_timing0_reg;
   logic [7:0] bus_timing1_reg;
   logic [8:0] tx_err_cnt = 9'h0;
   logic [31:0] send_id = 32'h0, rx_id, id_accept_pattern_regs, id_mask_regs;
   int fail_count = 0, n_tests = 0;
   cfim_top i_cfim_top (.core_clk, .srst, .cpu_stop, .sleep_ack, .soft_reset_lock, .global_irq_mask,
      .cfg_wr, .cfg_sel, .cfg_wdata, .rx_flag_clr, .tx_flag_clr, .irq_en, .tx_empty_irq_en, .rx_id,
      .rx_eof_ok, .rx_own_msg(own_msg), .bg_full, .tx_buf_set_empty, .tx_buf_sched, .bus_activity,
      .rx_err_cnt, .tx_err_cnt, .core_tx_bit(1'b0), .rx_flag_reg, .tx_flag_reg, .id_accept_control_reg,
      .module_control1_reg, .bus_timing0_reg, .bus_timing1_reg, .id_accept_pattern_regs,
      .id_mask_regs, .fg_copy, .op_mode, .proto_clk_en, .reg_clk_en, .can_tx_pin, .irq_wakeup,
      .irq_error, .irq_rx, .irq_tx);
   cfim_can_node i_cfim_can_node (.core_clk, .send, .send_id, .frame_len, .rx_id, .rx_eof_ok,
      .bus_activity);
   always #5 core_clk = ~core_clk;
   task automatic tick(input int n = 1);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic clr(input logic [7:0] m);
      rx_flag_clr = m;
      tick();
      rx_flag_clr = 8'h0;
      tick();
   endtask
   // Writes all pattern and mask bytes, then the mode, back to back
   task automatic bank(input logic lk, input logic [7:0] mode, input logic [31:0] pat, msk);
      logic [63:0] pm;
      pm = {pat, msk};
      soft_reset_lock = lk;
      for (int i = 0; i < 9; i++) begin
         cfg_sel = (i == 8) ? 4'h3 : 4'(4 + i);
         cfg_wdata = (i == 8) ? mode : pm[63 - 8 * i -: 8];
         cfg_wr = 1'b1;
         tick();
      end
      cfg_wr = 1'b0;
      soft_reset_lock = 1'b0;
      tick();
   endtask
   task automatic frame(input logic [31:0] id, input logic copy, input logic [1:0] hit);
      int k;
      send_id = id;
      send = 1'b1;
      tick();
      send = 1'b0;
      for (k = 0; k < 20 && rx_eof_ok !== 1'b1; k++) tick();
      if (k == 20) begin
         fail_count++;
         results();
      end
      tick();
      chk(fg_copy, copy);
      tick();
      if (copy) chk(id_accept_control_reg[1:0], hit);
   endtask
   task automatic t_ctrl;
      soft_reset_lock = 1'b1;
      cfg_wr = 1'b1;
      for (int i = 0; i < 3; i++) begin
         cfg_sel = 4'(i);
         cfg_wdata = 8'ha0 + 8'(i);
         tick();
      end
      cfg_wr = 1'b0;
      soft_reset_lock = 1'b0;
      tick();
      chk({module_control1_reg, bus_timing0_reg, bus_timing1_reg}, 32'h00a0a1a2);
   endtask
   task automatic t_filter;
      bank(1'b0, 8'h00, 32'hffffffff, 32'h0);
      chk(id_accept_pattern_regs, 32'h0);
      bank(1'b1, 8'h00, 32'h12345678, 32'h000000ff);
      chk(id_mask_regs, 32'h000000ff);
      frame(32'h123456aa, 1'b1, 2'h0);
      chk(irq_rx, 1'b1);
      bg_full = 1'b1;
      frame(32'h123456aa, 1'b0, 2'h0);
      chk(rx_flag_reg[1:0], 2'h3);
      chk(irq_error, 1'b1);
      bg_full = 1'b0;
      clr(8'h03);
      chk(irq_rx, 1'b0);
      frame(32'h133456aa, 1'b0, 2'h0);
      own_msg = 1'b1;
      frame(32'h123456aa, 1'b0, 2'h0);
      own_msg = 1'b0;
      bank(1'b1, 8'h10, 32'h12345678, 32'h0);
      frame(32'h56785678, 1'b1, 2'h1);
      clr(8'h01);
      bank(1'b1, 8'h20, 32'h11223322, 32'h0);
      frame(32'h22222222, 1'b1, 2'h1);
      clr(8'h01);
      bank(1'b1, 8'h30, 32'h0, 32'hffffffff);
      frame(32'h0, 1'b0, 2'h0);
      chk(rx_flag_reg[0], 1'b0);
   endtask
   task automatic t_error;
      rx_err_cnt = 8'h5f;
      tx_err_cnt = 9'h05f;
      tick(2);
      chk(rx_flag_reg[6:2], 5'h00);
      rx_err_cnt = 8'h60;
      tx_err_cnt = 9'h080;
      tick(2);
      chk(rx_flag_reg[6:2], 5'h1a);
      chk(irq_error, 1'b1);
      global_irq_mask = 1'b1;
      tick(2);
      chk(irq_error, 1'b0);
      global_irq_mask = 1'b0;
      irq_en = 8'h81;
      tick(2);
      chk(irq_error, 1'b0);
      irq_en = 8'hff;
      rx_err_cnt = 8'h80;
      tx_err_cnt = 9'h100;
      clr(8'h7c);
      chk(rx_flag_reg[6:2], 5'h1f);
      rx_err_cnt = 8'h0;
      tx_err_cnt = 9'h0;
      clr(8'h7c);
      chk(irq_error, 1'b0);
   endtask
   task automatic t_tx;
      chk(tx_flag_reg, 3'h7);
      tx_buf_sched = 3'h7;
      tick();
      tx_buf_sched = 3'h0;
      tx_empty_irq_en = 3'h4;
      tx_buf_set_empty = 3'h2;
      tick();
      tx_buf_set_empty = 3'h0;
      tick(2);
      chk(irq_tx, 1'b0);
      tx_empty_irq_en = 3'h2;
      tick(2);
      chk(irq_tx, 1'b1);
      tx_flag_clr = 3'h2;
      tick();
      tx_flag_clr = 3'h0;
      tick();
      chk(irq_tx, 1'b0);
   endtask
   task automatic t_wake;
      sleep_ack = 1'b1;
      frame_len = 4'hc;
      frame(32'h0, 1'b0, 2'h0);
      chk(irq_wakeup, 1'b1);
      sleep_ack = 1'b0;
      clr(8'h80);
      chk(irq_wakeup, 1'b0);
      chk(rx_flag_reg[7], 1'b0);
   endtask
   task automatic t_mode;
      logic [1:0] m;
      for (int i = 0; i < 8; i++) begin
         if (i == 3) continue;
         {cpu_stop, sleep_ack, soft_reset_lock} = 3'(i);
         m = i[2] ? 2'h3 : i[1] ? 2'h1 : i[0] ? 2'h2 : 2'h0;
         tick();
         chk(op_mode, m);
         chk(can_tx_pin, m != 2'h0);
         chk(reg_clk_en, m != 2'h3);
         chk(proto_clk_en, m == 2'h0);
      end
   endtask
   initial begin
      tick(6);
      srst = 1'b0;
      tick();
      t_tx();
      t_ctrl();
      t_filter();
      t_error();
      t_wake();
      t_mode();
      results();
   end
endmodule // cfim_top_test
